// ===== core/synth_ratio_consts.svh
`ifndef SYNTH_RATIO_CONSTS_SVH
`define SYNTH_RATIO_CONSTS_SVH

// byte addresses of the register bank (multi-byte fields are big endian)
`define ADDR_SYNTH0_FEC_RATIO      8'h54
`define ADDR_SYNTH1_BASE_RATE      8'h58
`define ADDR_SYNTH1_RATE_MULTIPLE  8'h5a
`define ADDR_SYNTH1_FEC_RATIO      8'h5c
`define ADDR_BANK_LAST             8'h5f

// reset values
`define RST_FEC_RATIO              32'h0001_0001
`define RST_SYNTH1_BASE_RATE       16'h61a8
`define RST_SYNTH1_RATE_MULTIPLE   16'h0c35
`define RST_FREQ_DIVISOR           16'h0001

// field positions inside a ratio word
`define RATIO_DIVISOR_LSB          0
`define RATIO_TOP_LSB              16

// fixed factor of the frequency formula
`define FREQ_FIXED_FACTOR          8'h10

`endif

// ===== core/synth_ratio_pkg.sv
package synth_ratio_pkg;
    typedef logic [7:0]  reg_addr_type;
    typedef logic [7:0]  reg_byte_type;
    typedef logic [15:0] half_word_type;
    typedef logic [31:0] ratio_word_type;
    typedef logic [63:0] freq_num_type;
endpackage

// ===== core/synth_freq_calc.sv
`timescale 1ns/1ps
`include "synth_ratio_consts.svh"

// synthesizer frequency numerator and divisor, registered
module synth_freq_calc
    import synth_ratio_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // operands
    input  wire half_word_type base_rate_hertz,
    input  wire half_word_type rate_multiple_count,
    input  wire half_word_type ratio_top_value,
    input  wire half_word_type ratio_divisor,
    // result: frequency in hertz = freq_numer / freq_divisor
    output freq_num_type       freq_numer,
    output half_word_type      freq_divisor
);
    // kept as a fraction; a real divider would cost far more than it buys
    freq_num_type numer_d;

    always_comb
    begin
        numer_d = freq_num_type'(base_rate_hertz) * freq_num_type'(rate_multiple_count)
                  * freq_num_type'(`FREQ_FIXED_FACTOR) * freq_num_type'(ratio_top_value); // R2
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freq_numer   <= '0;
            freq_divisor <= `RST_FREQ_DIVISOR;
        end
        else
        begin
            freq_numer   <= numer_d;      // R2
            freq_divisor <= ratio_divisor; // R2
        end
    end
endmodule

// ===== core/synth_ratio_regs.sv
// Behaviour
// R1: synth0 ratio word: divisor low, top high
// R2: frequency equals base*multiple*16*top/divisor
// R3: host sets top and divisor to one; the bank stores any value and the testbench writes others
// R4: synth1 base rate, reset 0x61a8
// R5: host writes only supported base-rate codes
// R6: synth1 rate multiple, reset 0x0c35
// R7: host keeps frequency within 1-1.5 GHz
// R8: equal frequencies only at 1.1 GHz up
// R9: host splits around 1.25 GHz for equality
`timescale 1ns/1ps
`include "synth_ratio_consts.svh"

module synth_ratio_regs
    import synth_ratio_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // byte-wide register port from the serial control engine
    input  wire logic          reg_wr_en,
    input  wire logic          reg_rd_en,
    input  wire reg_addr_type  reg_addr,
    input  wire reg_byte_type  reg_wr_data,
    output reg_byte_type       reg_rd_data,
    output logic               reg_rd_valid,
    // configuration toward the synthesizers
    output half_word_type      first_synth_ratio_divisor,
    output half_word_type      first_synth_ratio_top,
    output half_word_type      second_synth_base_rate,
    output half_word_type      second_synth_rate_multiple,
    output half_word_type      second_synth_ratio_divisor,
    output half_word_type      second_synth_ratio_top,
    // frequency of the second synthesizer as numerator over divisor
    output freq_num_type       second_synth_freq_numer,
    output half_word_type      second_synth_freq_divisor
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // asserts at once; release waits two edges so no flop sees it mid-edge
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    ratio_word_type synth0_fec_ratio_q;
    half_word_type  synth1_base_rate_q;
    half_word_type  synth1_rate_multiple_q;
    ratio_word_type synth1_fec_ratio_q;

    // byte lane within a field; lowest address holds the most significant byte
    function automatic logic [1:0] lane_of(input reg_addr_type a, input reg_addr_type base, input int unsigned nbytes);
        reg_addr_type off;
        off = a - base;
        lane_of = 2'(nbytes - 1 - int'(off));
    endfunction

    function automatic logic in_field(input reg_addr_type a, input reg_addr_type base, input int unsigned nbytes);
        in_field = (a >= base) && (int'(a) < int'(base) + int'(nbytes));
    endfunction

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one decode serves writes and reads, so the two cannot disagree
    logic       hit_synth0_ratio;
    logic       hit_synth1_base;
    logic       hit_synth1_multiple;
    logic       hit_synth1_ratio;

    // byte lane of the addressed byte, 0 = least significant
    logic [1:0] lane_synth0_ratio;
    logic [1:0] lane_synth1_base;
    logic [1:0] lane_synth1_multiple;
    logic [1:0] lane_synth1_ratio;

    assign hit_synth0_ratio     = in_field(reg_addr, `ADDR_SYNTH0_FEC_RATIO, 4);
    assign hit_synth1_base      = in_field(reg_addr, `ADDR_SYNTH1_BASE_RATE, 2);
    assign hit_synth1_multiple  = in_field(reg_addr, `ADDR_SYNTH1_RATE_MULTIPLE, 2);
    assign hit_synth1_ratio     = in_field(reg_addr, `ADDR_SYNTH1_FEC_RATIO, 4);

    assign lane_synth0_ratio    = lane_of(reg_addr, `ADDR_SYNTH0_FEC_RATIO, 4);
    assign lane_synth1_base     = lane_of(reg_addr, `ADDR_SYNTH1_BASE_RATE, 2);
    assign lane_synth1_multiple = lane_of(reg_addr, `ADDR_SYNTH1_RATE_MULTIPLE, 2);
    assign lane_synth1_ratio    = lane_of(reg_addr, `ADDR_SYNTH1_FEC_RATIO, 4);

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            synth0_fec_ratio_q <= `RST_FEC_RATIO; // R1
        end
        else if (reg_wr_en && hit_synth0_ratio)
        begin
            synth0_fec_ratio_q[8*lane_synth0_ratio +: 8] <= reg_wr_data; // R1
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            synth1_base_rate_q <= `RST_SYNTH1_BASE_RATE; // R4
        end
        else if (reg_wr_en && hit_synth1_base)
        begin
            // any code is stored; keeping to supported codes is software's job
            synth1_base_rate_q[8*lane_synth1_base +: 8] <= reg_wr_data; // R4
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            synth1_rate_multiple_q <= `RST_SYNTH1_RATE_MULTIPLE; // R6
        end
        else if (reg_wr_en && hit_synth1_multiple)
        begin
            synth1_rate_multiple_q[8*lane_synth1_multiple +: 8] <= reg_wr_data; // R6
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            synth1_fec_ratio_q <= `RST_FEC_RATIO;
        end
        else if (reg_wr_en && hit_synth1_ratio)
        begin
            synth1_fec_ratio_q[8*lane_synth1_ratio +: 8] <= reg_wr_data;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    reg_byte_type rd_data_d;

    always_comb
    begin
        rd_data_d = 8'h00; // unmapped bytes read zero
        if (hit_synth0_ratio)
        begin
            rd_data_d = synth0_fec_ratio_q[8*lane_synth0_ratio +: 8]; // R1
        end
        else if (hit_synth1_base)
        begin
            rd_data_d = synth1_base_rate_q[8*lane_synth1_base +: 8]; // R4
        end
        else if (hit_synth1_multiple)
        begin
            rd_data_d = synth1_rate_multiple_q[8*lane_synth1_multiple +: 8]; // R6
        end
        else if (hit_synth1_ratio)
        begin
            rd_data_d = synth1_fec_ratio_q[8*lane_synth1_ratio +: 8];
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            reg_rd_data  <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            // data holds between reads, so a late sampler still sees it
            if (reg_rd_en)
            begin
                reg_rd_data <= rd_data_d;
            end
        end
    end

    // ------------------------------------------------------------
    // field outputs
    // ------------------------------------------------------------
    // straight off the storage flops, no extra cycle
    assign first_synth_ratio_divisor  = synth0_fec_ratio_q[`RATIO_DIVISOR_LSB +: 16]; // R1
    assign first_synth_ratio_top      = synth0_fec_ratio_q[`RATIO_TOP_LSB +: 16];     // R1
    assign second_synth_base_rate     = synth1_base_rate_q;                           // R4
    assign second_synth_rate_multiple = synth1_rate_multiple_q;                       // R6
    assign second_synth_ratio_divisor = synth1_fec_ratio_q[`RATIO_DIVISOR_LSB +: 16];
    assign second_synth_ratio_top     = synth1_fec_ratio_q[`RATIO_TOP_LSB +: 16];

    // ------------------------------------------------------------
    // frequency of the second synthesizer
    // ------------------------------------------------------------
    synth_freq_calc synth_freq_calc_inst
    (
        .clk                 (clk),
        .rst_n               (rst_n_q),
        .base_rate_hertz     (synth1_base_rate_q),
        .rate_multiple_count (synth1_rate_multiple_q),
        .ratio_top_value     (synth1_fec_ratio_q[`RATIO_TOP_LSB +: 16]),
        .ratio_divisor       (synth1_fec_ratio_q[`RATIO_DIVISOR_LSB +: 16]),
        .freq_numer          (second_synth_freq_numer),
        .freq_divisor        (second_synth_freq_divisor)
    );

endmodule

// ===== test/synth_ratio_regs_checker.sv
`timescale 1ns/1ps
module synth_ratio_regs_checker
    import synth_ratio_pkg::*;
(
    // clock, reset and byte port
    input wire logic          clk,
    input wire logic          arst_n,
    input wire logic          reg_wr_en,
    input wire logic          reg_rd_en,
    input wire reg_addr_type  reg_addr,
    input wire reg_byte_type  reg_wr_data,
    input wire reg_byte_type  reg_rd_data,
    input wire logic          reg_rd_valid,
    // fields and frequency
    input wire half_word_type first_synth_ratio_divisor,
    input wire half_word_type first_synth_ratio_top,
    input wire half_word_type second_synth_base_rate,
    input wire half_word_type second_synth_rate_multiple,
    input wire half_word_type second_synth_ratio_divisor,
    input wire half_word_type second_synth_ratio_top,
    input wire freq_num_type  second_synth_freq_numer,
    input wire half_word_type second_synth_freq_divisor
);
    // edges since release; the frequency pipe is only trusted from the third
    logic [1:0] up_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    reset_view_a: assert property (up_q == 2'h1 |->
        first_synth_ratio_top == 16'h0001 && first_synth_ratio_divisor == 16'h0001 &&
        second_synth_base_rate == 16'h61a8 && second_synth_rate_multiple == 16'h0c35)
        else $error("reset values wrong");
    freq_formula_a: assert property (up_q == 2'h3 |->
        second_synth_freq_numer == {48'h0, $past(second_synth_base_rate)} * $past(second_synth_rate_multiple)
        * 64'h10 * $past(second_synth_ratio_top) && second_synth_freq_divisor == $past(second_synth_ratio_divisor))
        else $error("frequency disagrees with fields");
    top_byte_a: assert property (reg_wr_en && reg_addr == 8'h54 |=>
        first_synth_ratio_top[15:8] == $past(reg_wr_data)) else $error("ratio top byte not stored");
    divisor_byte_a: assert property (reg_wr_en && reg_addr == 8'h57 |=>
        first_synth_ratio_divisor[7:0] == $past(reg_wr_data)) else $error("divisor byte not stored");
    base_byte_a: assert property (reg_wr_en && reg_addr == 8'h58 |=>
        second_synth_base_rate[15:8] == $past(reg_wr_data)) else $error("base byte not stored");
    multiple_byte_a: assert property (reg_wr_en && reg_addr == 8'h5b |=>
        second_synth_rate_multiple[7:0] == $past(reg_wr_data)) else $error("multiple byte not stored");
    read_base_a: assert property (reg_rd_en && reg_addr == 8'h58 |=>
        reg_rd_valid && reg_rd_data == $past(second_synth_base_rate[15:8])) else $error("base read wrong");
endmodule

// ===== test/synth_host_model.sv
`timescale 1ns/1ps
module synth_host_model
    import synth_ratio_pkg::*;
(
    // byte port toward the bank
    input  wire logic         clk,
    output logic              reg_wr_en,
    output logic              reg_rd_en,
    output reg_addr_type      reg_addr,
    output reg_byte_type      reg_wr_data,
    input  wire reg_byte_type reg_rd_data,
    input  wire logic         reg_rd_valid
);
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    task automatic put(input reg_addr_type a, input reg_byte_type d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d;
    endtask
    task automatic get(input reg_addr_type a, output reg_byte_type d, output logic v);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        @(posedge clk);
        d = reg_rd_data;
        v = reg_rd_valid;
    endtask
    // only settings inside the legal frequency range, with supported base codes
    // two settings above 1.25 GHz, one below it
    function automatic logic [63:0] setting(input int k);
        case (k)
            0: return {16'h9c40, 16'h0798, 16'h00ff, 16'h00ed};
            1: return {16'h61a8, 16'h0c35, 16'h41be, 16'h3b80};
            default: return {16'h1f40, 16'h2000, 16'h0001, 16'h0001};
        endcase
    endfunction
endmodule

// ===== test/synth_ratio_regs_tb.sv
`timescale 1ns/1ps
module synth_ratio_regs_tb;
    import synth_ratio_pkg::*;
    logic          clk;
    logic          arst_n;
    logic          wr_en;
    logic          rd_en;
    reg_addr_type  addr;
    reg_byte_type  wdata;
    reg_byte_type  rdata;
    logic          rvalid;
    half_word_type f [6];
    half_word_type ex [6];
    freq_num_type  numer;
    half_word_type fdiv;
    logic [63:0]   s;
    int            errors;
    int            comparisons;
    integer        seed;
    // fields in address order: top0, divisor0, base, multiple, top1, divisor1
    synth_ratio_regs synth_ratio_regs_inst (.clk(clk), .arst_n(arst_n), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
        .reg_rd_valid(rvalid), .first_synth_ratio_divisor(f[1]), .first_synth_ratio_top(f[0]),
        .second_synth_base_rate(f[2]), .second_synth_rate_multiple(f[3]),
        .second_synth_ratio_divisor(f[5]), .second_synth_ratio_top(f[4]),
        .second_synth_freq_numer(numer), .second_synth_freq_divisor(fdiv));
    synth_host_model synth_host_model_inst (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rvalid));
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] v);
        comparisons++;
        if (v !== e)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, v);
        end
    endtask
    // reads every byte big endian and compares fields and frequency
    task automatic audit();
        reg_byte_type hi;
        reg_byte_type lo;
        logic         v;
        for (int k = 0; k < 6; k++)
        begin
            synth_host_model_inst.get(8'h54 + 8'(2 * k), hi, v);
            synth_host_model_inst.get(8'h55 + 8'(2 * k), lo, v);
            chk("read back", {48'h0, ex[k]}, {48'h0, hi, lo});
            chk("field", {48'h0, ex[k]}, {48'h0, f[k]});
            chk("valid", 64'h1, {63'h0, v});
        end
        synth_host_model_inst.get(8'h60, hi, v);
        chk("unmapped", 64'h0, {56'h0, hi});
        chk("numer", 64'(ex[2]) * ex[3] * 64'h10 * ex[4], numer);
        chk("divisor", {48'h0, ex[5]}, {48'h0, fdiv});
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        seed = 71;
        errors = 0;
        comparisons = 0;
        ex = '{16'h0001, 16'h0001, 16'h61a8, 16'h0c35, 16'h0001, 16'h0001};
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        audit();
        for (int i = 0; i < 8; i++)
        begin
            s = synth_host_model_inst.setting(i < 3 ? i : $unsigned($random(seed)) % 3);
            ex = '{16'($random(seed)), 16'($random(seed)) | 16'h0001, s[63:48], s[47:32], s[31:16], s[15:0]};
            if (i == 0)
            begin
                ex[0] = 16'hffff;
                ex[1] = 16'hffff;
            end
            for (int k = 0; k < 6; k++)
            begin
                synth_host_model_inst.put(8'h54 + 8'(2 * k), ex[k][15:8]);
                synth_host_model_inst.put(8'h55 + 8'(2 * k), ex[k][7:0]);
            end
            synth_host_model_inst.put(i[0] ? 8'h53 : 8'h60, 8'($random(seed)));
            audit();
        end
        // reset in mid-run: every field and the frequency fraction return to defaults
        arst_n <= 1'b0;
        @(posedge clk);
        chk("numer in reset", 64'h0, numer);
        chk("divisor in reset", 64'h1, {48'h0, fdiv});
        chk("valid in reset", 64'h0, {63'h0, rvalid});
        chk("base in reset", 64'h61a8, {48'h0, f[2]});
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        ex = '{16'h0001, 16'h0001, 16'h61a8, 16'h0c35, 16'h0001, 16'h0001};
        repeat (4) @(posedge clk);
        audit();
        tally_and_finish();
    end
endmodule
bind synth_ratio_regs synth_ratio_regs_checker synth_ratio_regs_checker_inst (.*);
